// ==== src/aout_defs.svh ====
`ifndef AOUT_DEFS_SVH
`define AOUT_DEFS_SVH

// ----------------------------------------------------------------
// Register indices (six-bit address of the control byte)
// ----------------------------------------------------------------
`define ADDR_RAW_CODE        6'h05
`define ADDR_FACTORY_OFFSET  6'h13
`define ADDR_FACTORY_GAIN    6'h14
`define ADDR_FACTORY_SAFE    6'h15
`define ADDR_UNLOCK_CODE     6'h1F
`define ADDR_FEATURE         6'h20
`define ADDR_USER_OFFSET     6'h21
`define ADDR_USER_GAIN       6'h22
`define ADDR_USER_SAFE       6'h23

// ----------------------------------------------------------------
// Reset values and codes
// ----------------------------------------------------------------
`define RST_FACTORY_OFFSET   16'h0000
`define RST_FACTORY_GAIN     16'h0020
`define RST_FACTORY_SAFE     16'h0000
`define RST_FEATURE          16'h0006
`define RST_USER_OFFSET      16'h0000
`define RST_USER_GAIN        16'h0100
`define RST_USER_SAFE        16'h0000
`define RST_UNLOCK_CODE      16'h0000
`define UNLOCK_VALUE         16'h1235
`define RAW_CODE_MAX         12'hFFF
`define GAIN_FRAC_BITS       8

// ----------------------------------------------------------------
// Feature register bit positions
// ----------------------------------------------------------------
`define FEAT_USER_SCALE      0
`define FEAT_FACTORY_SCALE   1
`define FEAT_WATCHDOG        2
`define FEAT_USER_SAFE       8

// ----------------------------------------------------------------
// Control byte bit positions
// ----------------------------------------------------------------
`define CB_REG_MODE          7
`define CB_TRIM_ON           6
`define CB_TRIM_GAIN         4
`define CB_TRIM_OFFSET       3
`define CB_FAST              2
`define CB_UP                1
`define CB_DOWN              0

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLK_HZ               40000000
`define CYCLES_PER_MS        (`CLK_HZ / 1000)
`define WDOG_MS              100
`define TRIM_SLOW_MS         1000
`define TRIM_FAST_MS         50
`define WDOG_CYCLES          (`CYCLES_PER_MS * `WDOG_MS)
`define TRIM_SLOW_CYCLES     (`CYCLES_PER_MS * `TRIM_SLOW_MS)
`define TRIM_FAST_CYCLES     (`CYCLES_PER_MS * `TRIM_FAST_MS)

`endif

// ==== src/aout_pkg.sv ====
`default_nettype none

package aout_pkg;

	// Process image layout settings
	typedef struct packed {
		logic complete_eval;
		logic swap_bytes;
		logic word_align;
	} image_cfg_type;

	// Control byte seen as register access
	typedef struct packed {
		logic       reg_mode;
		logic       write_not_read_flag;
		logic [5:0] addr;
	} ctrl_byte_type;

endpackage

`default_nettype wire

// ==== src/analog_output_scaling_watchdog.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "aout_defs.svh"

module analog_output_scaling_watchdog #(
	parameter int unsigned WDOG_CYCLES      = `WDOG_CYCLES,
	parameter int unsigned TRIM_SLOW_CYCLES = `TRIM_SLOW_CYCLES,
	parameter int unsigned TRIM_FAST_CYCLES = `TRIM_FAST_CYCLES
) (
	input  wire logic                   clk,
	input  wire logic                   rst,
	input  wire aout_pkg::image_cfg_type image_cfg,
	input  wire logic [63:0]            out_image,
	input  wire logic                   out_image_valid,
	output var  logic [63:0]            in_image_q,
	output var  logic                   in_image_valid_q,
	output var  logic [11:0]            dac_code_q [2],
	output var  logic                   nv_commit_q [2]
);
	import aout_pkg::*;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [7:0] get_byte(input logic [63:0] img, input logic [2:0] idx);
		get_byte = img[{idx, 3'b000} +: 8];
	endfunction

	function automatic logic [2:0] ctrl_pos(input image_cfg_type cfg, input logic ch);
		ctrl_pos = cfg.word_align ? {ch, 2'b00} : (ch ? 3'h3 : 3'h0);
	endfunction

	function automatic logic [2:0] data_pos(input image_cfg_type cfg, input logic ch,
		input logic high);
		logic [2:0] first;
		logic       swap;
		first = 3'h0;
		swap  = high ^ cfg.swap_bytes;
		if (!cfg.complete_eval)
			first = {1'b0, ch, 1'b0};
		else if (cfg.word_align)
			first = {ch, 2'b10};
		else
			first = ch ? 3'h4 : 3'h1;
		data_pos = first + {2'b00, swap};
	endfunction

	function automatic logic signed [47:0] line_eq(input logic signed [47:0] x,
		input logic signed [16:0] gain, input logic signed [15:0] off);
		logic signed [64:0] prod;
		prod    = 65'(x) * 65'(gain);
		line_eq = prod[55:8] + 48'(off);
	endfunction

	function automatic logic [11:0] sat12(input logic signed [47:0] v);
		if (v < 0)
			sat12 = 12'h000;
		else if (v > 48'sh0000_0000_0FFF)
			sat12 = `RAW_CODE_MAX;
		else
			sat12 = v[11:0];
	endfunction

	localparam logic [31:0] WDOG_LAST = 32'(WDOG_CYCLES - 1);
	localparam logic [31:0] SLOW_LAST = 32'(TRIM_SLOW_CYCLES - 1);
	localparam logic [31:0] FAST_LAST = 32'(TRIM_FAST_CYCLES - 1);

	logic [7:0]  status_w [2];
	logic [15:0] reply_w  [2];
	logic [63:0] image_d;

	// ----------------------------------------------------------------
	// Channels
	// ----------------------------------------------------------------
	for (genvar ch = 0; ch < 2; ch++)
	begin : g_chan
		logic [15:0]   code_q, foff_q, fgain_q, fsafe_q;
		logic [15:0]   feat_q, uoff_q, ugain_q, usafe_q;
		logic [15:0]   pd_word_q;
		logic [7:0]    trim_ctrl_q;
		logic [31:0]   wd_cnt_q, trim_cnt_q;
		logic          safe_q, dirty_q;

		logic [7:0]    ctrl_raw;
		ctrl_byte_type ctrl;
		logic [15:0]   data_word;
		logic          pd_stb, reg_stb, wr_stb, unlocked, prot_ok;
		logic          wr_code, wr_foff, wr_fgain, wr_fsafe;
		logic          wr_feat, wr_uoff, wr_ugain, wr_usafe;
		logic          wd_expire;
		logic          trim_on, trim_req, trim_tick, commit;
		logic [31:0]   trim_last;
		logic [15:0]   step;
		logic signed [47:0] s0, s1, s2;
		logic [11:0]   scaled, safe_code, dac_d;
		logic [15:0]   rd_data;

		// ----------------------------------------------------------------
		// Request decode
		// ----------------------------------------------------------------
		assign ctrl_raw  = image_cfg.complete_eval ?
			get_byte(out_image, ctrl_pos(image_cfg, 1'(ch))) : 8'h00;
		assign ctrl      = ctrl_byte_type'(ctrl_raw);
		assign data_word = {get_byte(out_image, data_pos(image_cfg, 1'(ch), 1'b1)),
			get_byte(out_image, data_pos(image_cfg, 1'(ch), 1'b0))};
		assign pd_stb    = out_image_valid & ~ctrl.reg_mode;
		assign reg_stb   = out_image_valid & ctrl.reg_mode;
		assign wr_stb    = reg_stb & ctrl.write_not_read_flag;
		assign unlocked  = (code_q == `UNLOCK_VALUE);
		assign prot_ok   = wr_stb & unlocked;

		assign wr_code  = wr_stb & (ctrl.addr == `ADDR_UNLOCK_CODE);
		assign wr_foff  = prot_ok & (ctrl.addr == `ADDR_FACTORY_OFFSET);
		assign wr_fgain = prot_ok & (ctrl.addr == `ADDR_FACTORY_GAIN);
		assign wr_fsafe = prot_ok & (ctrl.addr == `ADDR_FACTORY_SAFE);
		assign wr_feat  = prot_ok & (ctrl.addr == `ADDR_FEATURE);
		assign wr_uoff  = prot_ok & (ctrl.addr == `ADDR_USER_OFFSET);
		assign wr_ugain = prot_ok & (ctrl.addr == `ADDR_USER_GAIN);
		assign wr_usafe = prot_ok & (ctrl.addr == `ADDR_USER_SAFE);

		// ----------------------------------------------------------------
		// Trim stepping
		// ----------------------------------------------------------------
		assign trim_on   = ~trim_ctrl_q[`CB_REG_MODE] & trim_ctrl_q[`CB_TRIM_ON]
			& unlocked;
		assign trim_req  = trim_on & (trim_ctrl_q[`CB_UP] ^ trim_ctrl_q[`CB_DOWN])
			& (trim_ctrl_q[`CB_TRIM_GAIN] | trim_ctrl_q[`CB_TRIM_OFFSET]);
		assign trim_last = trim_ctrl_q[`CB_FAST] ? FAST_LAST : SLOW_LAST;
		assign trim_tick = trim_req & (trim_cnt_q >= trim_last);
		assign step      = trim_ctrl_q[`CB_UP] ? 16'h0001 : 16'hFFFF;
		// Leaving the unlock state saves pending trims
		assign commit    = wr_code & unlocked & (data_word != `UNLOCK_VALUE)
			& (dirty_q | trim_tick);

		always_ff @(posedge clk)
		begin
			if (rst | ~trim_req)
				trim_cnt_q <= 32'h0000_0000;
			else if (trim_tick)
				trim_cnt_q <= 32'h0000_0000;
			else
				trim_cnt_q <= trim_cnt_q + 32'h0000_0001;
		end

		always_ff @(posedge clk)
		begin
			if (rst)
				dirty_q <= 1'b0;
			else if (trim_tick)
				dirty_q <= 1'b1;
			else if (commit)
				dirty_q <= 1'b0;
		end

		// ----------------------------------------------------------------
		// Parameter registers
		// ----------------------------------------------------------------
		always_ff @(posedge clk)
		begin
			if (rst)
			begin
				code_q  <= `RST_UNLOCK_CODE;
				fsafe_q <= `RST_FACTORY_SAFE;
				feat_q  <= `RST_FEATURE;
				uoff_q  <= `RST_USER_OFFSET;
				ugain_q <= `RST_USER_GAIN;
				usafe_q <= `RST_USER_SAFE;
			end
			else
			begin
				if (wr_code)
					code_q <= data_word;
				if (wr_fsafe)
					fsafe_q <= data_word;
				if (wr_feat)
					feat_q <= data_word;
				if (wr_uoff)
					uoff_q <= data_word;
				if (wr_ugain)
					ugain_q <= data_word;
				if (wr_usafe)
					usafe_q <= data_word;
			end
		end

		// Trimmed terms; an explicit write overrides a step
		always_ff @(posedge clk)
		begin
			if (rst)
			begin
				foff_q  <= `RST_FACTORY_OFFSET;
				fgain_q <= `RST_FACTORY_GAIN;
			end
			else
			begin
				if (wr_foff)
					foff_q <= data_word;
				else if (trim_tick & trim_ctrl_q[`CB_TRIM_OFFSET])
					foff_q <= foff_q + step;
				if (wr_fgain)
					fgain_q <= data_word;
				else if (trim_tick & trim_ctrl_q[`CB_TRIM_GAIN])
					fgain_q <= fgain_q + step;
			end
		end

		// ----------------------------------------------------------------
		// Process data and watchdog
		// ----------------------------------------------------------------
		assign wd_expire = feat_q[`FEAT_WATCHDOG] & (wd_cnt_q >= WDOG_LAST);

		always_ff @(posedge clk)
		begin
			if (rst)
			begin
				pd_word_q   <= 16'h0000;
				trim_ctrl_q <= 8'h00;
			end
			else if (pd_stb)
			begin
				pd_word_q   <= data_word;
				trim_ctrl_q <= ctrl_raw;
			end
		end

		always_ff @(posedge clk)
		begin
			if (rst | pd_stb)
				wd_cnt_q <= 32'h0000_0000;
			else if (wd_cnt_q < WDOG_LAST)
				wd_cnt_q <= wd_cnt_q + 32'h0000_0001;
		end

		always_ff @(posedge clk)
		begin
			if (rst)
				safe_q <= 1'b1;
			else if (pd_stb)
				safe_q <= 1'b0;
			else if (wd_expire)
				safe_q <= 1'b1;
		end

		// ----------------------------------------------------------------
		// Scaling to the converter code
		// ----------------------------------------------------------------
		assign s0 = 48'($signed(pd_word_q));
		assign s1 = feat_q[`FEAT_FACTORY_SCALE] ?
			line_eq(s0, $signed({1'b0, fgain_q}), $signed(foff_q)) : s0;
		assign s2 = feat_q[`FEAT_USER_SCALE] ?
			line_eq(s1, $signed({ugain_q[15], ugain_q}), $signed(uoff_q)) : s1;
		assign scaled    = sat12(s2);
		assign safe_code = feat_q[`FEAT_USER_SAFE] ?
			sat12(48'($signed(usafe_q))) : fsafe_q[11:0];
		assign dac_d     = safe_q ? safe_code : scaled;

		always_ff @(posedge clk)
		begin
			if (rst)
			begin
				dac_code_q[ch]  <= 12'h000;
				nv_commit_q[ch] <= 1'b0;
			end
			else
			begin
				dac_code_q[ch]  <= dac_d;
				nv_commit_q[ch] <= commit;
			end
		end

		// ----------------------------------------------------------------
		// Read back and reply
		// ----------------------------------------------------------------
		always_comb
		begin
			case (ctrl.addr)
				`ADDR_RAW_CODE:       rd_data = {4'h0, dac_code_q[ch]};
				`ADDR_FACTORY_OFFSET: rd_data = foff_q;
				`ADDR_FACTORY_GAIN:   rd_data = fgain_q;
				`ADDR_FACTORY_SAFE:   rd_data = fsafe_q;
				`ADDR_UNLOCK_CODE:    rd_data = unlocked ? code_q : 16'h0000;
				`ADDR_FEATURE:        rd_data = feat_q;
				`ADDR_USER_OFFSET:    rd_data = uoff_q;
				`ADDR_USER_GAIN:      rd_data = ugain_q;
				`ADDR_USER_SAFE:      rd_data = usafe_q;
				default:              rd_data = 16'h0000;
			endcase
		end

		// Process mode status carries nothing; write ack drops bit 6
		assign status_w[ch] = ~ctrl.reg_mode ? 8'h00 :
			{ctrl.reg_mode, 1'b0, ctrl.addr};
		assign reply_w[ch]  = (reg_stb & ~ctrl.write_not_read_flag) ? rd_data : 16'h0000;
	end

	// ----------------------------------------------------------------
	// Input image assembly
	// ----------------------------------------------------------------
	always_comb
	begin
		image_d = 64'h0000_0000_0000_0000;
		for (int c = 0; c < 2; c++)
		begin
			if (image_cfg.complete_eval)
				image_d[{ctrl_pos(image_cfg, 1'(c)), 3'b000} +: 8] = status_w[c];
			image_d[{data_pos(image_cfg, 1'(c), 1'b0), 3'b000} +: 8] = reply_w[c][7:0];
			image_d[{data_pos(image_cfg, 1'(c), 1'b1), 3'b000} +: 8] = reply_w[c][15:8];
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			in_image_q       <= 64'h0000_0000_0000_0000;
			in_image_valid_q <= 1'b0;
		end
		else
		begin
			in_image_valid_q <= out_image_valid;
			if (out_image_valid)
				in_image_q <= image_d;
		end
	end

endmodule // analog_output_scaling_watchdog

`default_nettype wire

// ==== sim/aout_checker.sv ====
`timescale 1ns/1ps
`default_nettype none

module aout_checker
	import aout_pkg::*;
(
	input wire logic          clk,
	input wire logic          rst,
	input wire image_cfg_type image_cfg,
	input wire logic [63:0]   out_image,
	input wire logic          out_image_valid,
	input wire logic [63:0]   in_image_q,
	input wire logic          in_image_valid_q,
	input wire logic [11:0]   dac_code_q [2],
	input wire logic          nv_commit_q [2]
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	wire flat   = out_image_valid && image_cfg.complete_eval && !image_cfg.word_align;
	wire reg_rd = flat && out_image[7:6] == 2'b10;
	wire reg_wr = flat && out_image[7:6] == 2'b11;

	reply_pulse_a: assert property (out_image_valid |=> in_image_valid_q)
		else $error("reply pulse missing");
	quiet_reply_a: assert property (!out_image_valid |=> !in_image_valid_q)
		else $error("reply pulse without request");
	image_hold_a: assert property (!out_image_valid |=> $stable(in_image_q))
		else $error("reply image moved while idle");
	reset_clear_a: assert property (disable iff (1'b0)
		rst |=> in_image_q == 64'h0 && !in_image_valid_q && dac_code_q[0] == 12'h000)
		else $error("reset state wrong");
	plain_zero_a: assert property (out_image_valid && !image_cfg.complete_eval
		|=> in_image_q == 64'h0)
		else $error("plain image reply not zero");
	proc_status_a: assert property (flat && !out_image[7] |=> in_image_q[23:0] == 24'h0)
		else $error("process status not zero");
	read_echo_a: assert property (reg_rd |=> in_image_q[7:0] == $past(out_image[7:0]))
		else $error("read status not echoed");
	write_ack_a: assert property (reg_wr
		|=> in_image_q[23:0] == {16'h0, 2'b10, $past(out_image[5:0])})
		else $error("write acknowledge wrong");
	commit_pulse_a: assert property ($rose(nv_commit_q[0]) |-> $past(out_image_valid)
		##1 !nv_commit_q[0])
		else $error("commit pulse wrong");

	cover property (reg_rd);
	cover property (reg_wr);
	cover property (nv_commit_q[0]);
endmodule // aout_checker

bind analog_output_scaling_watchdog aout_checker i_checker (
	.clk              (clk),
	.rst              (rst),
	.image_cfg        (image_cfg),
	.out_image        (out_image),
	.out_image_valid  (out_image_valid),
	.in_image_q       (in_image_q),
	.in_image_valid_q (in_image_valid_q),
	.dac_code_q       (dac_code_q),
	.nv_commit_q      (nv_commit_q)
);

`default_nettype wire

// ==== sim/coupler_model.sv ====
`timescale 1ns/1ps
`default_nettype none

module coupler_model
	import aout_pkg::*;
(
	input  wire logic        clk,
	output var  logic [63:0] out_image,
	output var  logic        out_image_valid,
	input  wire logic [63:0] in_image_q,
	input  wire logic        in_image_valid_q
);
	initial
	begin
		out_image = 64'h0;
		out_image_valid = 1'b0;
	end

	function automatic int dpos(image_cfg_type cfg, int c);
		return cfg.complete_eval ? (cfg.word_align ? 4 * c + 2 : 3 * c + 1) : 2 * c;
	endfunction

	function automatic logic [63:0] pack(image_cfg_type cfg, int c, logic [7:0] ctl,
		logic [15:0] w, logic [63:0] img);
		int d;
		d = dpos(cfg, c);
		if (cfg.complete_eval)
			img[8 * (d - (cfg.word_align ? 2 : 1)) +: 8] = ctl;
		img[8 * (d + cfg.swap_bytes) +: 8] = w[7:0];
		img[8 * (d + !cfg.swap_bytes) +: 8] = w[15:8];
		return img;
	endfunction

	function automatic logic [15:0] word(image_cfg_type cfg, int c, logic [63:0] img);
		int d;
		d = dpos(cfg, c);
		return {img[8 * (d + !cfg.swap_bytes) +: 8], img[8 * (d + cfg.swap_bytes) +: 8]};
	endfunction

	// Idle image shows the inverse so stale bytes are never read as valid
	task automatic xfer(input logic [63:0] img, output logic [63:0] rep);
		@(negedge clk);
		out_image = img;
		out_image_valid = 1'b1;
		@(negedge clk);
		out_image_valid = 1'b0;
		out_image = ~img;
		rep = in_image_q;
	endtask
endmodule // coupler_model

`default_nettype wire

// ==== sim/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none

module testbench;
	import aout_pkg::*;
	localparam int WDOG = 50;
	localparam int LIMIT = 2000;
	localparam image_cfg_type REGCFG = 3'b100;
	typedef struct packed {
		image_cfg_type cfg;
		logic [15:0]   w0;
		logic [15:0]   w1;
		logic [11:0]   d0;
		logic [11:0]   d1;
	} row_type;
	row_type rows [4] = '{
		'{3'b000, 16'h0100, 16'h0008, 12'h020, 12'h001},
		'{3'b010, 16'h7FFF, 16'h8000, 12'hFFF, 12'h000},
		'{3'b100, 16'h1000, 16'hFFF8, 12'h200, 12'h000},
		'{3'b111, 16'h0010, 16'h2000, 12'h002, 12'h400}
	};
	logic [5:0]    addrs [9] = '{6'h14, 6'h15, 6'h20, 6'h21, 6'h22, 6'h23, 6'h13, 6'h1F, 6'h30};
	logic [15:0]   resets [9] = '{16'h0020, 16'h0000, 16'h0006, 16'h0000, 16'h0100,
		16'h0000, 16'h0000, 16'h0000, 16'h0000};
	logic          clk = 1'b0;
	logic          rst = 1'b1;
	image_cfg_type cfg = 3'b000;
	logic [63:0]   out_image;
	logic          out_image_valid;
	logic [63:0]   in_image_q;
	logic          in_image_valid_q;
	logic [11:0]   dac_code_q [2];
	logic          nv_commit_q [2];
	logic [63:0]   rep;
	logic [15:0]   v;
	logic          committed = 1'b0;
	int            num_errors = 0;
	int            total_checks = 0;
	int            cycles = 0;

	always #12.5 clk = ~clk;

	analog_output_scaling_watchdog #(
		.WDOG_CYCLES      (WDOG),
		.TRIM_SLOW_CYCLES (40),
		.TRIM_FAST_CYCLES (10)
	) i_dut (
		.clk              (clk),
		.rst              (rst),
		.image_cfg        (cfg),
		.out_image        (out_image),
		.out_image_valid  (out_image_valid),
		.in_image_q       (in_image_q),
		.in_image_valid_q (in_image_valid_q),
		.dac_code_q       (dac_code_q),
		.nv_commit_q      (nv_commit_q)
	);

	coupler_model i_coupler (
		.clk              (clk),
		.out_image        (out_image),
		.out_image_valid  (out_image_valid),
		.in_image_q       (in_image_q),
		.in_image_valid_q (in_image_valid_q)
	);

	task automatic close_out();
		$display("checks %0d mismatches %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	always @(negedge clk)
	begin
		cycles++;
		if (nv_commit_q[0] === 1'b1)
			committed = 1'b1;
		if (cycles == LIMIT)
		begin
			num_errors++;
			close_out();
		end
	end

	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic done(input string name);
		$display("test %s done", name);
	endtask

	task automatic reg_op(input logic [7:0] ctl, input logic [15:0] w);
		cfg = REGCFG;
		i_coupler.xfer(i_coupler.pack(REGCFG, 0, ctl, w, 64'h0), rep);
		v = i_coupler.word(REGCFG, 0, rep);
	endtask

	task automatic proc(input image_cfg_type c, input logic [7:0] ctl,
		input logic [15:0] w0, input logic [15:0] w1);
		cfg = c;
		i_coupler.xfer(i_coupler.pack(c, 1, 8'h00, w1, i_coupler.pack(c, 0, ctl, w0, 64'h0)), rep);
		@(negedge clk);
	endtask

	initial
	begin
		repeat (12) @(negedge clk);
		rst = 1'b0;
		@(negedge clk);
		check({52'h0, dac_code_q[0]}, 64'h0);
		done("reset");
		foreach (rows[i])
		begin
			proc(rows[i].cfg, 8'h00, rows[i].w0, rows[i].w1);
			check(rep, 64'h0);
			check({40'h0, dac_code_q[0], dac_code_q[1]}, {40'h0, rows[i].d0, rows[i].d1});
		end
		done("rows");
		foreach (addrs[i])
		begin
			reg_op({2'b10, addrs[i]}, 16'h0);
			check({48'h0, v}, {48'h0, resets[i]});
			check({56'h0, rep[7:0]}, {58'h2, addrs[i]});
		end
		done("registers");
		reg_op(8'hE2, 16'h0200);
		reg_op(8'hA2, 16'h0);
		check({48'h0, v}, 64'h0100);
		reg_op(8'hDF, 16'h1235);
		reg_op(8'h9F, 16'h0);
		check({48'h0, v}, 64'h1235);
		reg_op(8'hE2, 16'h0200);
		reg_op(8'hE0, 16'h0001);
		proc(REGCFG, 8'h00, 16'h0400, 16'h0);
		check({52'h0, dac_code_q[0]}, 64'h800);
		reg_op(8'h85, 16'h0);
		check({48'h0, v}, 64'h0800);
		done("lock");
		reg_op(8'hE3, 16'h0123);
		reg_op(8'hE0, 16'h0106);
		proc(REGCFG, 8'h00, 16'h0100, 16'h0);
		repeat (WDOG - 10) @(negedge clk);
		check({52'h0, dac_code_q[0]}, 64'h020);
		repeat (15) @(negedge clk);
		check({52'h0, dac_code_q[0]}, 64'h123);
		reg_op(8'hE0, 16'h0002);
		proc(REGCFG, 8'h00, 16'h0100, 16'h0);
		repeat (WDOG + 10) @(negedge clk);
		check({52'h0, dac_code_q[0]}, 64'h020);
		done("watchdog");
		proc(REGCFG, 8'h56, 16'h0100, 16'h0);
		repeat (31) @(negedge clk);
		proc(REGCFG, 8'h00, 16'h0100, 16'h0);
		check({52'h0, dac_code_q[0]}, 64'h023);
		proc(REGCFG, 8'h49, 16'h0100, 16'h0);
		repeat (43) @(negedge clk);
		proc(REGCFG, 8'h00, 16'h0100, 16'h0);
		check({52'h0, dac_code_q[0]}, 64'h022);
		check({63'h0, committed}, 64'h0);
		reg_op(8'hDF, 16'h0000);
		@(negedge clk);
		check({63'h0, committed}, 64'h1);
		reg_op(8'h9F, 16'h0);
		check({48'h0, v}, 64'h0);
		done("trim");
		rst = 1'b1;
		repeat (2) @(negedge clk);
		rst = 1'b0;
		@(negedge clk);
		check({52'h0, dac_code_q[0]}, 64'h0);
		reg_op(8'hA2, 16'h0);
		check({48'h0, v}, 64'h0100);
		done("reset again");
		close_out();
	end
endmodule // testbench

`default_nettype wire
